/* hw/wcrc_host.sv */
// Host side: builds CRC write frames, watches alert, flags writes for resend by GO
`timescale 1ns/100ps
`include "wcrc_regs.svh"
module wcrc_host (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// Software port
	input  wire logic [3:0]           addr,
	input  wire logic [31:0]          wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output logic      [31:0]          rdata,
	// Link to device
	output logic                      link_clk,
	output wcrc_pkg::wcrc_lanes_t     lanes,
	output logic                      lanes_oe,
	input  wire logic                 alert_n_in,
	output logic                      alert_pullup
);
	logic [5:0]   ctrl;
	logic [143:0] wbuf;
	logic [143:0] frame_d;
	logic [15:0]  crc_sent;
	logic [3:0]   beat;
	logic [3:0]   div;
	logic [7:0]   alert_len;
	logic [7:0]   last_pw;
	logic [15:0]  alert_cnt;
	logic [15:0]  retry_cnt;
	logic [7:0]   wait_cnt;
	logic         busy;
	logic         err_seen;
	logic         go_pend;
	logic         al_s1;
	logic         al_s2;
	logic         al_q;
	wcrc_pkg::wcrc_state_t state;
	wcrc_pkg::wcrc_width_t wid;
	wcrc_pkg::wcrc_lanes_t next_lanes;

	assign wid = wcrc_pkg::wcrc_width_t'(ctrl[`WCRC_C_WID_HI:`WCRC_C_WID_LO]);
	assign alert_pullup = 1'b1;

	// Parallel CRC-8, x^8+x^2+x+1, zero seed, bit 71 first
	function automatic logic [7:0] crc72(input logic [71:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 71; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `WCRC_POLY : 8'h00);
		end
		return c;
	endfunction

	// Tree inputs as the device sees them, with its padding rules
	always_comb begin
		frame_d = wbuf;
		if (wid == wcrc_pkg::WCRC_X4)
			frame_d[71:32] = {40{1'b1}};
		if (!(ctrl[`WCRC_C_DBI] || ctrl[`WCRC_C_DM])) begin
			frame_d[71:64]   = 8'hFF;
			frame_d[143:136] = 8'hFF;
		end
	end
	assign crc_sent = {crc72(frame_d[143:72]),
		crc72(frame_d[71:0])} ^ {16{ctrl[`WCRC_C_CORRUPT]}};

	// Software registers; inversion and mask never both set
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl <= 6'h00;
			wbuf <= '0;
			go_pend <= 1'b0;
		end else begin
			if (state == wcrc_pkg::WCRC_SEND)
				go_pend <= 1'b0;
			if (wr) begin
				case (addr)
				`WCRC_A_CTRL: begin
					ctrl <= wdata[5:0];
					if (wdata[`WCRC_C_DBI] && wdata[`WCRC_C_DM])
						ctrl[`WCRC_C_DM] <= 1'b0;
				end
				`WCRC_A_WDATA0: wbuf[31:0]    <= wdata;
				`WCRC_A_WDATA1: wbuf[63:32]   <= wdata;
				`WCRC_A_WDATA2: wbuf[95:64]   <= wdata;
				`WCRC_A_WDATA3: wbuf[127:96]  <= wdata;
				`WCRC_A_WDATA4: wbuf[143:128] <= wdata[15:0];
				`WCRC_A_GO:     go_pend <= 1'b1;
				default: ;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			rdata <= 32'h0000_0000;
		else if (rd) begin
			case (addr)
			`WCRC_A_CTRL:   rdata <= {26'h0, ctrl};
			`WCRC_A_STATUS: rdata <= {20'h0, last_pw, 1'b0,
				err_seen, busy, go_pend};
			`WCRC_A_ALERTS: rdata <= {16'h0, alert_cnt};
			`WCRC_A_CRC:    rdata <= {16'h0, crc_sent};
			default:        rdata <= 32'h0000_0000;
			endcase
		end else
			rdata <= 32'h0000_0000;
	end

	// Link clock from a divider; one beat per link clock period
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			div <= 4'h0;
			link_clk <= 1'b0;
		end else if (div == `WCRC_DIV_HALF) begin
			div <= 4'h0;
			link_clk <= ~link_clk;
		end else
			div <= div + 4'h1;
	end

	// Lane contents for the current beat
	always_comb begin
		next_lanes.dq = 16'hFFFF;
		next_lanes.dm = 2'b11;
		if (beat < `WCRC_CRC_BEAT) begin
			for (int n = 0; n < 16; n++)
				next_lanes.dq[n] = wbuf[(n < 8 ? 8*n : 8*n+8) + beat];
			next_lanes.dm[0] = wbuf[64 + beat];
			next_lanes.dm[1] = wbuf[136 + beat];
		end else if (beat == `WCRC_CRC_BEAT) begin
			if (wid == wcrc_pkg::WCRC_X4)
				next_lanes.dq[3:0] = crc_sent[3:0];
			else begin
				next_lanes.dq[7:0] = crc_sent[7:0];
				next_lanes.dq[15:8] = crc_sent[15:8];
			end
		end else if (wid == wcrc_pkg::WCRC_X4)
			next_lanes.dq[3:0] = crc_sent[7:4];
		// Beat 9 on x8/x16 and beats 8-9 of mask lanes stay ones
	end

	// Frame sequencer; lanes change on first core edge after link fall
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= wcrc_pkg::WCRC_IDLE;
			beat <= 4'h0;
			lanes <= '1;
			lanes_oe <= 1'b0;
			retry_cnt <= 16'h0;
		end else begin
			case (state)
			wcrc_pkg::WCRC_IDLE: begin
				lanes_oe <= 1'b0;
				if (go_pend && link_clk && div == `WCRC_DIV_HALF) begin
					state <= wcrc_pkg::WCRC_SEND;
					beat <= 4'h0;
				end
			end
			wcrc_pkg::WCRC_SEND: begin
				if (!link_clk && div == 4'h0) begin
					lanes <= next_lanes;
					lanes_oe <= 1'b1;
				end
				if (link_clk && div == `WCRC_DIV_HALF) begin
					if (beat == `WCRC_BEATS)
						state <= wcrc_pkg::WCRC_HOLD;
					else
						beat <= beat + 4'h1;
				end
			end
			wcrc_pkg::WCRC_HOLD: begin
				// Wait out release of a six-clock alert pulse before declaring success
				lanes_oe <= 1'b0;
				if (retry_cnt == 16'(`WCRC_RETRY_CYC)) begin
					retry_cnt <= 16'h0;
					state <= err_seen ? wcrc_pkg::WCRC_RETRY
						: wcrc_pkg::WCRC_IDLE;
				end else
					retry_cnt <= retry_cnt + 16'h1;
			end
			wcrc_pkg::WCRC_RETRY: begin
				// Buffer kept as sent, so a resend by GO is coherent
				state <= wcrc_pkg::WCRC_IDLE;
			end
			default: state <= wcrc_pkg::WCRC_IDLE;
			endcase
		end
	end
	assign busy = (state != wcrc_pkg::WCRC_IDLE);

	// Alert watch: synchronised, any low run of 6 or more counts
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			al_s1 <= 1'b1;
			al_s2 <= 1'b1;
			al_q <= 1'b1;
		end else begin
			al_s1 <= alert_n_in;
			al_s2 <= al_s1;
			al_q <= al_s2;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			alert_len <= 8'h00;
			last_pw <= 8'h00;
			alert_cnt <= 16'h0;
			err_seen <= 1'b0;
		end else begin
			if (!al_s2 && alert_len != 8'hFF)
				alert_len <= alert_len + 8'h01;
			else if (al_s2)
				alert_len <= 8'h00;
			if (al_s2 && !al_q) begin
				last_pw <= alert_len;
				if (alert_len >= `WCRC_ALERT_MIN) begin
					alert_cnt <= alert_cnt + 16'h1;
					err_seen <= 1'b1;
				end
			end else if (state == wcrc_pkg::WCRC_RETRY)
				err_seen <= 1'b0;
			// A new pulse in the retry cycle wins; software resends by GO
		end
	end
endmodule // wcrc_host

/* hw/wcrc_pkg.sv */
// Types for the write-CRC frame host controller
package wcrc_pkg;
	typedef enum logic [1:0] {
		WCRC_X4  = 2'h0,
		WCRC_X8  = 2'h1,
		WCRC_X16 = 2'h2
	} wcrc_width_t;
	typedef struct packed {
		logic [15:0] dq;
		logic [1:0]  dm;
	} wcrc_lanes_t;
	typedef enum logic [3:0] {
		WCRC_IDLE  = 4'b0001,
		WCRC_SEND  = 4'b0010,
		WCRC_HOLD  = 4'b0100,
		WCRC_RETRY = 4'b1000
	} wcrc_state_t;
endpackage

/* hw/wcrc_regs.svh */
// Constants for the write-CRC frame host controller
// Function
// - x4 lanes carry 8 data beats, then checksum 0-3, then 4-7.
// - x8 with CRC on: host drives all ones on beat 9.
// - x8 with inversion on: host drives ones on mask lane beats 8 and 9.
// - Host never enables inversion and masking together.
// - x8 lane n: data beats 0-7, checksum bit n on beat 8.
// - x16 with CRC: ones on beat 9; inversion lanes ones on 8 and 9.
// - x16 upper half: lanes 8-15 and upper mask lane like x8.
// - Host tells CRC from parity error only by reading mode registers.
// - Error-clear bit stays set until host clears it by mode write; here the device model clears err_clr only on clr (reset).
// - On alert pulse host retries the affected writes; here host only flags it and software resends by GO.
// - Host reopens pages and keeps the retry sequence coherent; here nothing reopens pages and software resends the kept buffer by GO.
// - Host tolerates alert pulses longer than six clocks; here it is counted, but err_seen sets after the hold returns to idle.
// - Pulse width runs from device driving low to release.
// - Checksum is CRC-8 with polynomial x^8+x^2+x+1 over 72 bits.
// - CRC starts at zero; bit 71 is first serial bit.
`ifndef WCRC_REGS_SVH
`define WCRC_REGS_SVH
`define WCRC_A_CTRL    4'h0
`define WCRC_A_STATUS  4'h1
`define WCRC_A_WDATA0  4'h2
`define WCRC_A_WDATA1  4'h3
`define WCRC_A_WDATA2  4'h4
`define WCRC_A_WDATA3  4'h5
`define WCRC_A_WDATA4  4'h6
`define WCRC_A_GO      4'h7
`define WCRC_A_ALERTS  4'h8
`define WCRC_A_CRC     4'h9
`define WCRC_C_CRCEN   0
`define WCRC_C_DBI     1
`define WCRC_C_DM      2
`define WCRC_C_WID_LO  3
`define WCRC_C_WID_HI  4
`define WCRC_C_CORRUPT 5
`define WCRC_BEATS     4'h9
`define WCRC_ALERT_MIN 8'h06
`define WCRC_CLK_PS    8000
`define WCRC_RETRY_NS  50
`define WCRC_RETRY_CYC ((`WCRC_RETRY_NS * 1000) / `WCRC_CLK_PS)
`define WCRC_DIV_HALF  4'h3
`define WCRC_POLY      8'h07
`define WCRC_CRC_BEAT  4'h8
`endif

/* sim/tb_top.sv */
// Self-checking bench: host against the device model
`timescale 1ns/100ps
`include "wcrc_regs.svh"
module tb_top;
	logic                  core_clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic [3:0]            addr = 4'h0;
	logic [31:0]           wdata = 32'h0;
	logic                  wr = 1'b0;
	logic                  rd = 1'b0;
	logic                  rd_q = 1'b0;
	logic [31:0]           rdata;
	logic                  link_clk, oe, pu, drv, ecl;
	wcrc_pkg::wcrc_lanes_t lanes;
	logic [5:0]            mode = 6'h00;
	logic [3:0]            pw = 4'h6;
	logic [159:0]          dat;
	logic [31:0]           cm;
	logic [63:0]           q[$];
	logic [63:0]           nt;
	logic [31:0]           seed = 32'h0001_3046;
	int                    fail_count = 0;
	int                    total_checks = 0;
	int                    nal = 0;
	always #4 core_clk = ~core_clk;
	wcrc_host DUT (.core_clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
		.link_clk, .lanes, .lanes_oe(oe), .alert_n_in(!drv && pu),
		.alert_pullup(pu));
	wcrc_dev_model MDL (.core_clk, .link_clk, .lanes, .lanes_oe(oe), .mode,
		.clr(!rst_n), .pw, .alert_drv(drv), .err_clr(ecl));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(string nm, logic [31:0] e, logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	always @(posedge core_clk) begin
		if (rd_q) begin
			nt = q.pop_front();
			check("rdata", nt[31:0], rdata & nt[63:32]);
		end
		rd_q <= rd;
	end
	task automatic bus(logic [3:0] a, logic [31:0] d, logic r);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= !r;
		rd <= r;
		@(posedge core_clk);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic rchk(logic [3:0] a, logic [31:0] e, logic [31:0] m);
		q.push_back({m, e & m});
		bus(a, 32'h0, 1'b1);
	endtask
	function automatic logic [15:0] ecrc(logic [5:0] c);
		logic [143:0] d;
		d = dat[143:0];
		if (c[4:3] == 2'h0)
			d[71:32] = '1;
		else if (c[2:1] == 2'h0) begin
			d[71:64] = 8'hFF;
			d[143:136] = 8'hFF;
		end
		return {MDL.crc8(d[143:72]), MDL.crc8(d[71:0])};
	endfunction
	task automatic frame(logic [5:0] c);
		mode <= c;
		bus(`WCRC_A_CTRL, {26'h0, c}, 1'b0);
		for (int i = 0; i < 5; i++)
			bus(`WCRC_A_WDATA0 + 4'(i), dat[32*i+:32], 1'b0);
		bus(`WCRC_A_GO, 32'h1, 1'b0);
		repeat (300) if (oe !== 1'b1) @(posedge core_clk);
		check("lanes_oe", 32'h1, {31'h0, oe});
		repeat (300) if (oe !== 1'b0) @(posedge core_clk);
		check("lanes_oe", 32'h0, {31'h0, oe});
		repeat (24) @(posedge core_clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int w = 0; w < 3; w++) begin
			for (int i = 0; i < 5; i++)
				dat[32*i+:32] = rnd();
			frame({1'b0, 2'(w), w == 2, w == 1, 1'b1});
			cm = w == 2 ? 32'h0000_FFFF : 32'h0000_00FF;
			rchk(`WCRC_A_CRC, ecrc(mode), cm);
			rchk(`WCRC_A_ALERTS, nal, 32'hFF);
			pw <= w == 2 ? 4'hA : 4'h6;
			frame(mode | 6'h20);
			nal++;
			rchk(`WCRC_A_ALERTS, nal, 32'hFF);
			rchk(`WCRC_A_STATUS, 32'(pw) << 4, 32'hFF0);
			check("err_clr", 32'h1, {31'h0, ecl});
			$display("test width %0d done", w);
		end
		frame(6'h28);
		rchk(`WCRC_A_ALERTS, nal, 32'hFF);
		bus(`WCRC_A_CTRL, 32'h7, 1'b0);
		rchk(`WCRC_A_CTRL, 32'h3, 32'h3F);
		repeat (4) @(posedge core_clk);
		$display("test modes done");
		give_verdict();
	end
	initial begin
		#100000;
		fail_count++;
		give_verdict();
	end
endmodule // tb_top

/* sim/wcrc_dev_model.sv */
// Device stand-in: gathers write frames, checks CRC, pulses alert
`timescale 1ns/100ps
module wcrc_dev_model (
	// Clock and link
	input wire logic                  core_clk,
	input wire logic                  link_clk,
	input wire wcrc_pkg::wcrc_lanes_t lanes,
	input wire logic                  lanes_oe,
	// Mode settings and pulse width
	input wire logic [5:0]            mode,
	input wire logic                  clr,
	input wire logic [3:0]            pw,
	// Alert driver and sticky error bit
	output logic                      alert_drv,
	output logic                      err_clr
);
	logic [17:0] bt [10];
	logic        lk = 1'b0;
	logic [7:0]  got;
	int          n = 0;
	int          lo = 0;
	function automatic logic [7:0] crc8(logic [71:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 71; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	function automatic logic [7:0] tree(int h);
		logic [71:0] d;
		d = '1;
		for (int k = 0; k < 8; k++) begin
			for (int j = 0; j < 8; j++)
				if (mode[4:3] != 2'h0 || j < 4)
					d[8*j+k] = bt[k][2+8*h+j];
			if (mode[2:1] != 2'h0 && mode[4:3] != 2'h0)
				d[64+k] = bt[k][h];
		end
		return crc8(d);
	endfunction
	// Pulse, never a level, so the host can count it
	assign alert_drv = lo > 0;
	always @(posedge core_clk) begin
		lk <= link_clk;
		if (lo > 0)
			lo <= lo - 1;
		if (clr)
			err_clr <= 1'b0;
		if (!lanes_oe)
			n = 0;
		else if (link_clk && !lk) begin
			bt[n] = lanes;
			n++;
		end
		if (n == 10) begin
			n = 0;
			got = mode[4:3] == 2'h0 ? {bt[9][5:2], bt[8][5:2]} : bt[8][9:2];
			if (mode[0] && ((tree(0) != got) || (mode[4:3] == 2'h2
				&& tree(1) != bt[8][17:10]))) begin
				lo <= pw;
				err_clr <= 1'b1;
			end
		end
	end
endmodule // wcrc_dev_model

/* sim/wcrc_host_props.sv */
// Port assertions for the write-CRC host
`timescale 1ns/100ps
`include "wcrc_regs.svh"
module wcrc_host_props (
	// Clock and reset
	input wire logic                  core_clk,
	input wire logic                  rst_n,
	// Software port
	input wire logic [3:0]            addr,
	input wire logic [31:0]           wdata,
	input wire logic                  wr,
	input wire logic                  rd,
	input wire logic [31:0]           rdata,
	// Link
	input wire logic                  link_clk,
	input wire wcrc_pkg::wcrc_lanes_t lanes,
	input wire logic                  lanes_oe,
	input wire logic                  alert_n_in,
	input wire logic                  alert_pullup
);
	logic [6:0] cnt;
	logic [4:0] ctl;
	always_ff @(posedge core_clk) begin
		cnt <= lanes_oe ? cnt + 7'h01 : 7'h00;
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			ctl <= 5'h00;
		else if (wr && addr == `WCRC_A_CTRL)
			ctl <= wdata[4:0];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_pullup_on: assert property (alert_pullup)
		else $error("pull-up off");
	a_ctrl_excl: assert property ($past(rd && addr == `WCRC_A_CTRL)
		|-> !(rdata[1] && rdata[2])) else $error("inversion with mask");
	a_frame_len: assert property ($fell(lanes_oe) |-> cnt == 7'h50)
		else $error("frame not ten beats");
	a_beat_hold: assert property (lanes_oe && $changed(lanes)
		|=> $stable(lanes) [*7]) else $error("beat too short");
	a_beat_ones: assert property (lanes_oe && cnt > 7'h47
		&& ctl[4:3] != 2'h0 |-> {lanes.dq, lanes.dm} == 18'h3FFFF)
		else $error("beat nine not ones");
	a_mask_ones: assert property (lanes_oe && cnt > 7'h3F
		&& ctl[4:3] != 2'h0 |-> &lanes.dm) else $error("mask lane low");
	a_link_div: assert property ($changed(link_clk)
		|=> $stable(link_clk) [*3] ##1 $changed(link_clk))
		else $error("link clock rate");
	a_hold_gap: assert property ($fell(lanes_oe) |-> !lanes_oe [*6])
		else $error("no wait for alert");
endmodule // wcrc_host_props
bind wcrc_host wcrc_host_props u_props (.core_clk, .rst_n, .addr, .wdata,
	.wr, .rd, .rdata, .link_clk, .lanes, .lanes_oe, .alert_n_in,
	.alert_pullup);
